//--- logic_cell.sv
// programmable logic cell: eight tables, combining muxes, feedback, nine storage elements
//
// Function
// - active-low global clear acts asynchronously on storage
// - local set/clear is synchronous or asynchronous
// - set-or-clear chosen per storage element
// - source select picks direct input or table
// - each control line disableable and invertible
// - disabled clock enable means always enabled
// - disabled local set/clear never acts
// - disabled source select uses one fixed source
// - memory mode maps enables onto write control
// - table goes out, to storage, or mux
// - only even/odd pairs mux onto even output
// - five-input function from two tables plus line
// - nibble four-to-one gives six-input dedicated output
// - both nibbles give six-input or eight-to-one selector
// - any mix of four- and five-input functions
// - internal feedback allows three table levels deep
// - fed-back output still registered and driven out
// - half-logic: upper nibble logic, lower nibble ripple
// - half-logic ninth element general or carry register
// - memory mode direct inputs carry data and address
`timescale 1ns/1ps
module logic_cell (
  input  wire logic                                  ref_clk_in,
  input  wire logic                                  reset_n_in,
  input  wire logic [1:0]                            mode_cfg_in,
  input  wire logic [logic_cell_pkg::TABLE_CFG_W-1:0] table_cfg_in,
  input  wire logic [3:0]                            pair_mux_cfg_in,
  input  wire logic [7:4]                            feedback_en_cfg_in,
  input  wire logic [3:0]                            feedback_low_sel_cfg_in,
  input  wire logic [5:0]                            feedback_high_sel_cfg_in,
  input  wire logic [8:0]                            set_cfg_in,
  input  wire logic                                  lsr_sync_cfg_in,
  input  wire logic [2:0]                            clk_route_cfg_in,
  input  wire logic [2:0]                            ce_route_cfg_in,
  input  wire logic [2:0]                            lsr_route_cfg_in,
  input  wire logic [2:0]                            lsr_group_en_cfg_in,
  input  wire logic [1:0]                            clk_dis_cfg_in,
  input  wire logic [1:0]                            clk_inv_cfg_in,
  input  wire logic [1:0]                            ce_dis_cfg_in,
  input  wire logic [1:0]                            ce_inv_cfg_in,
  input  wire logic [1:0]                            lsr_dis_cfg_in,
  input  wire logic [1:0]                            lsr_inv_cfg_in,
  input  wire logic [1:0]                            sel_dis_cfg_in,
  input  wire logic [1:0]                            sel_inv_cfg_in,
  input  wire logic [1:0]                            sel_fixed_cfg_in,
  input  wire logic                                  ninth_src_cfg_in,
  input  wire logic [31:0]                           table_in,
  input  wire logic [3:0]                            fifth_input_line_in,
  input  wire logic [7:0]                            direct_in,
  input  wire logic                                  carry_in,
  input  wire logic [1:0]                            cell_clock_in,
  input  wire logic [1:0]                            clock_enable_in,
  input  wire logic [1:0]                            local_set_clear_in,
  input  wire logic [1:0]                            source_select_in,
  output logic      [7:0]                            comb_out,
  output logic      [7:0]                            reg_out,
  output logic                                       ninth_out,
  output logic                                       carry_out,
  output logic                                       lower_six_input_out,
  output logic                                       upper_six_input_out,
  output logic                                       write_enable_out
);

  // mode decode
  logic       is_logic;
  logic       is_half;
  logic       is_ripple;
  logic       is_memory;
  logic [7:0] ripple_lane;
  assign is_logic    = (mode_cfg_in == logic_cell_pkg::MODE_LOGIC);
  assign is_half     = (mode_cfg_in == logic_cell_pkg::MODE_HALF);
  assign is_ripple   = (mode_cfg_in == logic_cell_pkg::MODE_RIPPLE);
  assign is_memory   = (mode_cfg_in == logic_cell_pkg::MODE_MEMORY);
  assign ripple_lane = is_ripple ? 8'hFF : (is_half ? 8'h0F : 8'h00);

  // control lines after disable and inversion
  logic [1:0] clk_eff;
  logic [1:0] clk_prev;
  logic [1:0] clk_edge;
  logic [1:0] ce_eff;
  logic [1:0] lsr_eff;
  logic [1:0] sel_eff;
  assign clk_eff  = ~clk_dis_cfg_in & (cell_clock_in ^ clk_inv_cfg_in);
  assign clk_edge = clk_eff & ~clk_prev;
  assign ce_eff   = ce_dis_cfg_in | (clock_enable_in ^ ce_inv_cfg_in);
  assign lsr_eff  = ~lsr_dis_cfg_in & (local_set_clear_in ^ lsr_inv_cfg_in);
  assign sel_eff  = (sel_dis_cfg_in & sel_fixed_cfg_in)
                  | (~sel_dis_cfg_in & (source_select_in ^ sel_inv_cfg_in));

  // cell clock is a routed level; its rising edge is detected on ref_clk_in
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      clk_prev <= 2'b00;
    end else begin
      clk_prev <= clk_eff;
    end
  end

  // per-group clock, enable and local set/clear routing
  logic [2:0] grp_tick;
  logic [2:0] grp_ce;
  logic [2:0] grp_lsr;
  genvar g;
  generate
    for (g = 0; g < logic_cell_pkg::GROUP_COUNT; g++) begin : g_group
      assign grp_tick[g] = clk_edge[clk_route_cfg_in[g]];
      assign grp_ce[g]   = ce_eff[ce_route_cfg_in[g]];
      assign grp_lsr[g]  = lsr_group_en_cfg_in[g] & lsr_eff[lsr_route_cfg_in[g]];
    end
  endgenerate

  // memory mode write control: enable line 1 writes, enable 0 and set/clear 0 gate the port
  logic wren;
  assign wren = is_memory & ce_eff[1] & ce_eff[0] & lsr_eff[0];

  // table evaluation with softwired feedback; only forward paths, so no loop can form
  logic [7:0]  tab;
  logic [7:0]  pair;
  logic [31:0] tab_idx;
  logic [3:0]  fb_low_cand;
  logic [7:0]  fb_high_cand;
  logic        lower_six;
  logic        upper_six;
  assign fb_low_cand  = pair[3:0];
  assign fb_high_cand = {1'b0, lower_six, tab[5], pair[4], pair[3:0]};

  genvar i;
  generate
    for (i = 0; i < logic_cell_pkg::TABLE_COUNT; i++) begin : g_table
      logic [logic_cell_pkg::TABLE_BITS-1:0] row;
      logic                                  fb_bit;
      assign row = table_cfg_in[i*logic_cell_pkg::TABLE_BITS +: logic_cell_pkg::TABLE_BITS];
      if (i < 4) begin : g_first
        assign fb_bit = table_in[i*4+3];
      end else if (i < 6) begin : g_second
        assign fb_bit = feedback_en_cfg_in[i]
                      ? fb_low_cand[feedback_low_sel_cfg_in[(i-4)*2 +: 2]]
                      : table_in[i*4+3];
      end else begin : g_third
        assign fb_bit = feedback_en_cfg_in[i]
                      ? fb_high_cand[feedback_high_sel_cfg_in[(i-6)*3 +: 3]]
                      : table_in[i*4+3];
      end
      assign tab_idx[i*4 +: 4] = {fb_bit, table_in[i*4 +: 3]};
      assign tab[i] = row[tab_idx[i*4 +: 4]];
      // even slot may be the pair mux steered by a fifth-input line; odd slot is plain
      if (i % 2 == 0) begin : g_even
        assign pair[i] = (pair_mux_cfg_in[i/2] & fifth_input_line_in[i/2]) ? tab[i+1] : tab[i];
      end else begin : g_odd
        assign pair[i] = tab[i];
      end
    end
  endgenerate

  // nibble four-to-one selectors: six-input function or eight-to-one selector
  assign lower_six = tab[{1'b0, fifth_input_line_in[1:0]}];
  assign upper_six = tab[{1'b1, fifth_input_line_in[3:2]}];

  // ripple chain: operands on table inputs 1 and 0 of each lane
  logic [8:0] chain;
  logic [7:0] ripple_sum;
  assign chain[0] = carry_in;
  generate
    for (i = 0; i < logic_cell_pkg::TABLE_COUNT; i++) begin : g_ripple
      logic op_a;
      logic op_b;
      assign op_a           = table_in[i*4+1];
      assign op_b           = table_in[i*4];
      assign ripple_sum[i]  = op_a ^ op_b ^ chain[i];
      assign chain[i+1]     = (op_a & op_b) | (chain[i] & (op_a ^ op_b));
    end
  endgenerate

  logic chain_out;
  assign chain_out = is_ripple ? chain[8] : (is_half ? chain[4] : carry_in); // half uses nibble chain

  // memory: 16 words of 4 bits in flip-flops, read by table slot zero inputs
  logic [logic_cell_pkg::MEM_WIDTH-1:0]  mem [logic_cell_pkg::MEM_DEPTH];
  logic [logic_cell_pkg::MEM_ADDR_W-1:0] mem_waddr;
  logic [logic_cell_pkg::MEM_WIDTH-1:0]  mem_wdata;
  logic [logic_cell_pkg::MEM_WIDTH-1:0]  mem_rdata;
  assign mem_waddr = direct_in[logic_cell_pkg::MEM_ADDR_LSB +: logic_cell_pkg::MEM_ADDR_W];
  assign mem_wdata = direct_in[logic_cell_pkg::MEM_DATA_LSB +: logic_cell_pkg::MEM_WIDTH];
  assign mem_rdata = mem[table_in[3:0]];

  generate
    for (i = 0; i < logic_cell_pkg::MEM_DEPTH; i++) begin : g_mem
      // one word; written on the memory clock edge when the port is enabled
      always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
          mem[i] <= 4'h0;
        end else if (wren && grp_tick[logic_cell_pkg::GROUP_LOW] && (mem_waddr == 4'(i))) begin
          mem[i] <= mem_wdata;
        end
      end
    end
  endgenerate

  // data slot outputs per mode
  logic [7:0] slot_out;
  assign slot_out = is_memory ? {4'h0, mem_rdata}
                  : ((ripple_lane & ripple_sum) | (~ripple_lane & pair));

  // storage element next values
  logic [8:0] store;
  logic [8:0] next_store;
  logic [8:0] elem_tick;
  logic [8:0] elem_ce;
  logic [8:0] elem_lsr;
  logic [8:0] elem_d;
  logic       ninth_d;
  assign ninth_d = (ninth_src_cfg_in == logic_cell_pkg::NINTH_FROM_CHAIN_OUT) ? chain_out : carry_in;

  generate
    for (i = 0; i < logic_cell_pkg::STORE_COUNT; i++) begin : g_store
      localparam int GRP = (i < 4) ? 0 : ((i < 8) ? 1 : 2);
      assign elem_tick[i] = grp_tick[GRP];
      assign elem_ce[i]   = grp_ce[GRP];
      assign elem_lsr[i]  = grp_lsr[GRP] & ~is_memory;
      if (i < logic_cell_pkg::NINTH) begin : g_byte
        assign elem_d[i] = sel_eff[GRP] ? slot_out[i] : direct_in[i];
      end else begin : g_ninth
        assign elem_d[i] = ninth_d;
      end
      // set/clear wins over load; async mode acts without a cell clock edge
      assign next_store[i] = (elem_lsr[i] && (!lsr_sync_cfg_in || elem_tick[i])) ? set_cfg_in[i]
                           : (elem_tick[i] && elem_ce[i] && !is_memory) ? elem_d[i]
                           : store[i];
    end
  endgenerate

  // storage, cleared by the global reset at any time
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      store <= logic_cell_pkg::STORE_RESET;
    end else begin
      store <= next_store;
    end
  end

  // output registers; combinational results appear one reference cycle later
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      comb_out            <= logic_cell_pkg::BYTE_RESET;
      carry_out           <= 1'b0;
      lower_six_input_out <= 1'b0;
      upper_six_input_out <= 1'b0;
      write_enable_out    <= 1'b0;
    end else begin
      comb_out            <= slot_out;
      carry_out           <= chain_out;
      lower_six_input_out <= lower_six;
      upper_six_input_out <= upper_six;
      write_enable_out    <= wren;
    end
  end

  assign reg_out   = store[7:0];
  assign ninth_out = store[logic_cell_pkg::NINTH];

  // checks wait one cycle after release, while outputs still hold their reset values
  logic live;
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      live <= 1'b0;
    end else begin
      live <= 1'b1;
    end
  end

  // checks
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (!live);

  property p_async_local;
    (!is_memory && grp_lsr[0] && !lsr_sync_cfg_in) |=> (store[0] == $past(set_cfg_in[0]));
  endproperty
  a_async_local: assert property (p_async_local) else $error("async local set/clear missed");

  property p_sync_local_waits;
    (!is_memory && grp_lsr[0] && lsr_sync_cfg_in && !grp_tick[0]) |=> (store[0] == $past(store[0]));
  endproperty
  a_sync_local_waits: assert property (p_sync_local_waits) else $error("sync set/clear acted early");

  property p_enable_disabled;
    (!is_memory && grp_tick[0] && !grp_lsr[0] && ce_dis_cfg_in[ce_route_cfg_in[0]])
      |=> (store[0] == $past(elem_d[0]));
  endproperty
  a_enable_disabled: assert property (p_enable_disabled) else $error("disabled enable blocked load");

  property p_lsr_disabled;
    (lsr_dis_cfg_in == 2'b11 && !grp_tick[1]) |=> $stable(store[7:4]);
  endproperty
  a_lsr_disabled: assert property (p_lsr_disabled) else $error("storage changed without edge");

  property p_fixed_source;
    (!is_memory && sel_dis_cfg_in[0] && sel_fixed_cfg_in[0] && grp_tick[0] && grp_ce[0] && !grp_lsr[0])
      |=> (store[1] == $past(slot_out[1]));
  endproperty
  a_fixed_source: assert property (p_fixed_source) else $error("fixed table source ignored");

  property p_write_enable;
    (is_memory && ce_eff[1] && ce_eff[0] && lsr_eff[0]) |=> write_enable_out;
  endproperty
  a_write_enable: assert property (p_write_enable) else $error("write enable map wrong");

  property p_write_blocked;
    (!is_memory || !ce_eff[1]) |=> !write_enable_out;
  endproperty
  a_write_blocked: assert property (p_write_blocked) else $error("write enable outside memory port");

  property p_mem_write;
    (wren && grp_tick[0]) |=> (mem[$past(mem_waddr)] == $past(mem_wdata));
  endproperty
  a_mem_write: assert property (p_mem_write) else $error("memory word not written");

  property p_pair_even;
    (is_logic && pair_mux_cfg_in[1] && fifth_input_line_in[1]) |=> (comb_out[2] == $past(tab[3]));
  endproperty
  a_pair_even: assert property (p_pair_even) else $error("pair mux not on even output");

  property p_six_low;
    !is_memory |=> (lower_six_input_out == $past(tab[{1'b0, fifth_input_line_in[1:0]}]));
  endproperty
  a_six_low: assert property (p_six_low) else $error("six-input output wrong");

  property p_six_high;
    !is_memory |=> (upper_six_input_out == $past(tab[{1'b1, fifth_input_line_in[3:2]}]));
  endproperty
  a_six_high: assert property (p_six_high) else $error("upper six-input output wrong");

  property p_half_carry;
    is_half |=> (carry_out == $past(chain[4]));
  endproperty
  a_half_carry: assert property (p_half_carry) else $error("half-logic chain not nibble");

  property p_ninth_chain;
    (is_half && (ninth_src_cfg_in == logic_cell_pkg::NINTH_FROM_CHAIN_OUT) && grp_tick[2] && grp_ce[2] && !grp_lsr[2])
      |=> (ninth_out == $past(chain[4]));
  endproperty
  a_ninth_chain: assert property (p_ninth_chain) else $error("ninth element missed nibble carry");

endmodule

//--- logic_cell_pkg.sv
// shared constants and types for the programmable logic cell
package logic_cell_pkg;

  // table geometry
  localparam int TABLE_COUNT  = 8;
  localparam int TABLE_INPUTS = 4;
  localparam int TABLE_BITS   = 16;
  localparam int TABLE_CFG_W  = TABLE_COUNT * TABLE_BITS;
  localparam int NIBBLE       = 4;

  // storage elements: eight table registers plus the ninth
  localparam int STORE_COUNT  = 9;
  localparam int NINTH        = 8;

  // control groups: lower nibble, upper nibble, ninth element
  localparam int GROUP_COUNT  = 3;
  localparam int GROUP_LOW    = 0;
  localparam int GROUP_HIGH   = 1;
  localparam int GROUP_NINTH  = 2;

  // memory mode: data on direct inputs 3..0, address on 7..4
  localparam int MEM_DEPTH    = 16;
  localparam int MEM_WIDTH    = 4;
  localparam int MEM_ADDR_W   = 4;
  localparam int MEM_DATA_LSB = 0;
  localparam int MEM_ADDR_LSB = 4;

  // feedback selector widths
  localparam int FB_LOW_SEL_W  = 2;
  localparam int FB_HIGH_SEL_W = 3;

  // ninth element source choices
  localparam logic NINTH_FROM_CARRY_IN  = 1'b0;
  localparam logic NINTH_FROM_CHAIN_OUT = 1'b1;

  // reset value of every storage element and output
  localparam logic [8:0] STORE_RESET = 9'h000;
  localparam logic [7:0] BYTE_RESET  = 8'h00;

  // cell operating modes
  typedef enum logic [1:0] {
    MODE_LOGIC  = 2'b00,
    MODE_HALF   = 2'b01,
    MODE_RIPPLE = 2'b10,
    MODE_MEMORY = 2'b11
  } cell_mode_t;

endpackage

//--- cell_routing_model.sv
// routing model that issues cell clock pulses into the logic cell
`timescale 1ns/1ps
module cell_routing_model (
  input  wire logic       ref_clk_in,
  input  wire logic       fire_in,
  output logic      [1:0] cell_clock_out
);
  // clock stands low outside a pulse so every request gives exactly one edge
  always @(posedge ref_clk_in) begin
    cell_clock_out <= fire_in ? 2'h3 : 2'h0;
  end
endmodule

//--- lut_logic_cell_control_bench.sv
// self-checking testbench for the logic cell control and combining paths
`timescale 1ns/1ps
module lut_logic_cell_control_bench;
  logic         ref_clk, reset_n, fire, lsr_sync, ninth_src, carry;
  logic [1:0]   mode, clk_dis, clk_inv, ce_dis, ce_inv, lsr_dis, lsr_inv, sel_dis, sel_inv, sel_fixed;
  logic [1:0]   cell_clock, clock_enable, local_set_clear, source_select;
  logic [2:0]   clk_route, ce_route, lsr_route, lsr_group_en;
  logic [3:0]   pair_mux, fifth, fb_en, fb_low;
  logic [5:0]   fb_high;
  logic [7:0]   direct, comb, regs;
  logic [8:0]   set_cfg;
  logic [31:0]  tab_in;
  logic [127:0] tab_cfg;
  logic         ninth, carry_o, low_six, up_six, wren;
  int           fail_count, checked;

  cell_routing_model cell_routing_model_i (.ref_clk_in(ref_clk), .fire_in(fire), .cell_clock_out(cell_clock));

  logic_cell logic_cell_i (
    .ref_clk_in(ref_clk), .reset_n_in(reset_n), .mode_cfg_in(mode), .table_cfg_in(tab_cfg),
    .pair_mux_cfg_in(pair_mux), .feedback_en_cfg_in(fb_en), .feedback_low_sel_cfg_in(fb_low),
    .feedback_high_sel_cfg_in(fb_high), .set_cfg_in(set_cfg), .lsr_sync_cfg_in(lsr_sync),
    .clk_route_cfg_in(clk_route), .ce_route_cfg_in(ce_route), .lsr_route_cfg_in(lsr_route),
    .lsr_group_en_cfg_in(lsr_group_en), .clk_dis_cfg_in(clk_dis), .clk_inv_cfg_in(clk_inv),
    .ce_dis_cfg_in(ce_dis), .ce_inv_cfg_in(ce_inv), .lsr_dis_cfg_in(lsr_dis), .lsr_inv_cfg_in(lsr_inv),
    .sel_dis_cfg_in(sel_dis), .sel_inv_cfg_in(sel_inv), .sel_fixed_cfg_in(sel_fixed),
    .ninth_src_cfg_in(ninth_src), .table_in(tab_in), .fifth_input_line_in(fifth), .direct_in(direct),
    .carry_in(carry), .cell_clock_in(cell_clock), .clock_enable_in(clock_enable),
    .local_set_clear_in(local_set_clear), .source_select_in(source_select), .comb_out(comb),
    .reg_out(regs), .ninth_out(ninth), .carry_out(carry_o), .lower_six_input_out(low_six),
    .upper_six_input_out(up_six), .write_enable_out(wren)
  );

  // free-running 250 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  task automatic chk(input string what, input logic [8:0] seen, input logic [8:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic settle();
    repeat (2) @(posedge ref_clk);
    #1;
  endtask

  // one cell clock edge, then room for the storage update to show
  task automatic pulse();
    @(posedge ref_clk) fire <= 1'b1;
    @(posedge ref_clk) fire <= 1'b0;
    repeat (4) @(posedge ref_clk);
    #1;
  endtask

  task automatic wrap_up();
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic t_load();
    chk("reset regs", {ninth, regs}, 9'h000);
    @(posedge ref_clk) begin direct <= 8'hA5; carry <= 1'b1; end
    pulse();
    chk("direct load", {ninth, regs}, 9'h1A5);
    @(posedge ref_clk) begin tab_cfg <= '1; sel_dis <= 2'h0; source_select <= 2'h3; end
    pulse();
    chk("table load", regs, 9'h0FF);
    @(posedge ref_clk) sel_inv <= 2'h3;
    pulse();
    chk("inverted select", regs, 9'h0A5);
  endtask

  task automatic t_enable();
    @(posedge ref_clk) begin
      sel_dis <= 2'h3; sel_inv <= 2'h0; ce_dis <= 2'h0; clock_enable <= 2'h1;
      ce_route <= 3'h2; direct <= 8'h3C;
    end
    pulse();
    chk("nibble enable", regs, 9'h0AC);
    @(posedge ref_clk) ce_dis <= 2'h3;
    pulse();
    chk("enable disabled", regs, 9'h03C);
  endtask

  task automatic t_set_clear();
    @(posedge ref_clk) begin lsr_dis <= 2'h0; set_cfg <= 9'h10F; local_set_clear <= 2'h1; end
    settle();
    chk("async set clear", {ninth, regs}, 9'h10F);
    @(posedge ref_clk) begin local_set_clear <= 2'h0; lsr_sync <= 1'b1; direct <= 8'h00; carry <= 1'b0; end
    pulse();
    @(posedge ref_clk) local_set_clear <= 2'h1;
    settle();
    chk("sync waits", {ninth, regs}, 9'h000);
    pulse();
    chk("sync at edge", {ninth, regs}, 9'h10F);
    @(posedge ref_clk) begin lsr_dis <= 2'h3; direct <= 8'h55; end
    pulse();
    chk("set clear disabled", regs, 9'h055);
    @(posedge ref_clk) reset_n <= 1'b0;
    settle();
    chk("global clear", {ninth, regs}, 9'h000);
    @(posedge ref_clk) reset_n <= 1'b1;
  endtask

  task automatic t_combine();
    @(posedge ref_clk) begin tab_cfg <= {96'h0, 16'hFFFF, 16'h0000}; pair_mux <= 4'h1; fifth <= 4'h1; end
    settle();
    chk("pair one", comb, 9'h003);
    @(posedge ref_clk) fifth <= 4'h0;
    settle();
    chk("pair zero", comb, 9'h002);
    @(posedge ref_clk) begin tab_cfg <= {16'h0, 16'hFFFF, 48'h0, 16'hFFFF, 32'h0}; pair_mux <= 4'h0; fifth <= 4'hA; end
    settle();
    chk("six hit", {low_six, up_six}, 9'h003);
    @(posedge ref_clk) fifth <= 4'h5;
    settle();
    chk("six miss", {low_six, up_six}, 9'h000);
    @(posedge ref_clk) begin pair_mux <= 4'h2; fifth <= 4'h2; end
    settle();
    chk("second pair on even", comb, 9'h040);
  endtask

  task automatic t_memory();
    @(posedge ref_clk) begin
      mode <= 2'h3; ce_dis <= 2'h0; lsr_dis <= 2'h0; lsr_sync <= 1'b0; ce_route <= 3'h0;
      clock_enable <= 2'h3; local_set_clear <= 2'h1; direct <= 8'h5A; tab_in <= 32'h5;
    end
    settle();
    chk("write enable on", wren, 9'h001);
    pulse();
    chk("memory word", comb, 9'h00A);
    @(posedge ref_clk) clock_enable <= 2'h1;
    settle();
    chk("write enable off", wren, 9'h000);
  endtask

  // table 0 feeds table 4, which feeds table 6: three levels, all still driven out
  task automatic t_feedback();
    @(posedge ref_clk) begin
      mode <= 2'h0; ce_dis <= 2'h3; lsr_dis <= 2'h3; sel_fixed <= 2'h3; tab_in <= 32'h0; fifth <= 4'h0;
      tab_cfg <= 128'h0000FF000000FF00000000000000FFFF; fb_en <= 4'h5; fb_low <= 4'h0; fb_high <= 6'h04;
    end
    pulse();
    chk("feedback three deep", comb, 9'h051);
    chk("feedback registered", regs, 9'h051);
    @(posedge ref_clk) fb_en <= 4'h0;
    settle();
    chk("feedback off", comb, 9'h001);
  endtask

  // lower nibble adds 11 + 6, upper nibble stays logic; then the full byte ripples
  task automatic t_half();
    @(posedge ref_clk) begin mode <= 2'h1; ninth_src <= 1'b1; tab_in <= 32'h00082132; end
    pulse();
    chk("half sum", comb, 9'h011);
    chk("half carry", carry_o, 9'h001);
    chk("ninth takes chain", {ninth, regs}, 9'h111);
    @(posedge ref_clk) mode <= 2'h2;
    settle();
    chk("full ripple", {carry_o, comb}, 9'h011);
  endtask

  // reset, configuration defaults, then the scenarios in turn
  initial begin
    fail_count = 0; checked = 0; reset_n = 1'b0; fire = 1'b0; lsr_sync = 1'b0; ninth_src = 1'b0;
    carry = 1'b0; mode = 2'h0; clk_dis = 2'h0; clk_inv = 2'h0; ce_dis = 2'h3; ce_inv = 2'h0;
    lsr_dis = 2'h3; lsr_inv = 2'h0; sel_dis = 2'h3; sel_inv = 2'h0; sel_fixed = 2'h0;
    clock_enable = 2'h0; local_set_clear = 2'h0; source_select = 2'h0; clk_route = 3'h0;
    ce_route = 3'h0; lsr_route = 3'h0; lsr_group_en = 3'h7; pair_mux = 4'h0; fifth = 4'h0;
    direct = 8'h00; set_cfg = 9'h000; tab_in = 32'h0; tab_cfg = '0;
    fb_en = 4'h0; fb_low = 4'h0; fb_high = 6'h00;
    repeat (16) @(posedge ref_clk);
    reset_n <= 1'b1;
    settle();
    t_load();
    t_enable();
    t_set_clear();
    t_combine();
    t_memory();
    t_feedback();
    t_half();
    wrap_up();
  end

  // watchdog against a hang
  initial begin
    repeat (5000) @(posedge ref_clk);
    fail_count++;
    wrap_up();
  end
endmodule
